// File: src/cbis_top.sv
// board interrupt steering: direct levels, priority unit, flag, bus line
// assumes an AHB-Lite master on hclk; all pins come from other domains
`timescale 1ns/10ps
module cbis_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pwr_fail_req,
    input wire logic mains_loss_indication,
    input wire logic general_timer_14bit_out,
    input wire logic general_timer_16bit_out,
    input wire logic [3:0] ring_ind,
    input wire logic [3:0] carrier_det,
    input wire logic channel0_receive_ready,
    input wire logic channel0_transmit_ready,
    input wire logic channel1_receive_ready,
    input wire logic channel1_transmit_ready,
    input wire logic channel2_receive_ready,
    input wire logic channel2_transmit_ready,
    input wire logic channel3_receive_ready,
    input wire logic channel3_transmit_ready,
    input wire logic [7:0] bus_interrupt_lines_n_i,
    output logic [7:0] bus_interrupt_lines_n_o,
    output logic [7:0] bus_interrupt_lines_oe,
    input wire logic bm_wr_strobe,
    input wire logic [19:0] bm_addr,
    output logic power_fail_trap,
    output logic level2_req,
    output logic level3_req,
    output logic level4_req,
    output logic maskable_request_input
);
    import cbis_pkg::*;

    cbis_state_t r;
    cbis_state_t n;
    logic [`CBIS_SYNC_W-1:0] pins;
    logic acc;
    logic rd;
    logic tmr;
    logic bm_hit;
    logic flag_rd;
    logic pic_ack;
    logic pic_eoi;
    logic [7:0] modem;
    logic [7:0] busn;
    logic pf_lvl;
    logic l3_raw;
    logic l4_raw;
    logic [7:0] irr;
    logic [7:0] isr;
    logic [23:0] call_instr;

    // ====================================================
    // pin gathering; every pin crosses two flops before use
    assign pins = {bm_addr, bm_wr_strobe, bus_interrupt_lines_n_i,
                   channel3_transmit_ready, channel3_receive_ready,
                   channel2_transmit_ready, channel2_receive_ready,
                   channel1_transmit_ready, channel1_receive_ready,
                   channel0_transmit_ready, channel0_receive_ready,
                   carrier_det, ring_ind, general_timer_16bit_out,
                   general_timer_14bit_out, mains_loss_indication, pwr_fail_req};

    // ====================================================
    // bus slave: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign acc = hsel && hready && htrans[1];
    assign rd = acc && !hwrite;
    assign flag_rd = rd && haddr[7:0] == `CBIS_OFS_FLAG;
    assign pic_ack = rd && haddr[7:0] == `CBIS_OFS_ACK;
    assign pic_eoi = r.wr_pend && r.wr_ofs == `CBIS_OFS_EOI;

    // ====================================================
    // source decode from the second synchroniser stage only
    assign modem = r.s2[`CBIS_S_MODEM];
    assign busn = r.s2[`CBIS_S_BUSN];
    assign tmr = r.cfg[`CBIS_CFG_TMR_EN] &&
                 (r.cfg[`CBIS_CFG_TMR_SEL] ? r.s2[`CBIS_S_T16] : r.s2[`CBIS_S_T14]); // [R03]
    // mains loss is treated as a power-down just like the bus request
    assign pf_lvl = r.cfg[`CBIS_CFG_PF_EN] && (r.s2[`CBIS_S_PF] || r.s2[`CBIS_S_ML]); // [R02] [R17]
    assign l3_raw = |modem; // [R04] [R20]
    // the jumper picks the window flag or one active-low bus line
    assign l4_raw = r.cfg[`CBIS_CFG_L4_BUS] ? !busn[r.cfg[`CBIS_CFG_L4_LINE]] : r.flag; // [R06]
    // window base must sit on a 4K page and the offset must be zero
    assign bm_hit = r.s2[`CBIS_S_BMWR] && !r.bm_d &&
                    r.s2[48:41] == r.cfg[`CBIS_CFG_PAGE] && r.s2[40:29] == 12'h000; // [R07] [R16]

    // ====================================================
    // direct processor levels; power-fail has no mask bit at all
    assign power_fail_trap = pf_lvl; // [R01] [R02] [R09]
    assign level2_req = r.l2_lat && !r.dmask[`CBIS_DM_L2]; // [R09]
    assign level3_req = l3_raw && !r.dmask[`CBIS_DM_L3]; // [R09]
    assign level4_req = l4_raw && !r.dmask[`CBIS_DM_L4]; // [R09]

    // ====================================================
    // serial output bit pulls the one selected bus line low
    generate
        for (genvar g = 0; g < 8; g++)
        begin : g_bus
            assign bus_interrupt_lines_n_o[g] = 1'b0;
            assign bus_interrupt_lines_oe[g] = r.cfg[`CBIS_CFG_SOD_EN] && r.dmask[`CBIS_DM_SOD] &&
                                               r.cfg[`CBIS_CFG_SOD_LINE] == 3'(g); // [R15]
        end
    endgenerate

    // ====================================================
    // priority unit takes the eight channel ready requests only
    cbis_pic u_pic (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(r.s2[`CBIS_S_RDY]), // [R10]
        .mask(r.pmask),
        .rotate(r.pcfg[`CBIS_PC_ROT]),
        .interval8(r.pcfg[`CBIS_PC_INT8]),
        .base(r.pcfg[`CBIS_PC_BASE]),
        .ack(pic_ack),
        .eoi(pic_eoi),
        .maskable_request_input(maskable_request_input),
        .irr(irr),
        .isr(isr),
        .call_instr(call_instr)
    );

    // ====================================================
    // next-state logic
    always_comb
    begin
        n = r;
        n.s1 = pins;
        n.s2 = r.s1;
        n.bm_d = r.s2[`CBIS_S_BMWR];
        n.tmr_d = tmr;
        // address phase: remember a full-word write for its data phase
        n.wr_pend = acc && hwrite && hsize == 3'h2;
        n.wr_ofs = haddr[7:0];
        // data phase writes; unmapped offsets are dropped
        if (r.wr_pend)
        begin
            case (r.wr_ofs)
                `CBIS_OFS_CFG: n.cfg = hwdata;
                `CBIS_OFS_DMASK: n.dmask = {27'h0000000, 1'b0, hwdata[3:0]};
                `CBIS_OFS_PMASK: n.pmask = hwdata[7:0]; // [R12]
                `CBIS_OFS_PCFG: n.pcfg = hwdata[15:0]; // [R18]
                default: n.cfg = r.cfg;
            endcase
        end
        // edge latch: cleared by software, a new edge in the same cycle wins
        if (r.wr_pend && r.wr_ofs == `CBIS_OFS_DMASK && hwdata[`CBIS_DM_CLR2])
            n.l2_lat = 1'b0;
        if (tmr && !r.tmr_d)
            n.l2_lat = 1'b1; // [R03]
        // flag stays up as a level until the processor reads the base
        if (flag_rd)
            n.flag = 1'b0; // [R08]
        if (bm_hit)
            n.flag = 1'b1; // [R07] [R19]
        // read data captured at the end of the address phase
        n.rdata = 32'h00000000;
        if (rd)
        begin
            case (haddr[7:0])
                `CBIS_OFS_CFG: n.rdata = r.cfg;
                `CBIS_OFS_DMASK: n.rdata = r.dmask;
                `CBIS_OFS_STAT: n.rdata = {isr, irr, modem, 2'h0, maskable_request_input,
                                           l4_raw, r.flag, l3_raw, r.l2_lat, pf_lvl}; // [R05]
                `CBIS_OFS_FLAG: n.rdata = {31'h00000000, r.flag};
                `CBIS_OFS_PMASK: n.rdata = {24'h000000, r.pmask};
                `CBIS_OFS_PCFG: n.rdata = {16'h0000, r.pcfg};
                `CBIS_OFS_ACK: n.rdata = {8'h00, call_instr}; // [R13] [R14]
                default: n.rdata = 32'h00000000;
            endcase
        end
    end

    // ====================================================
    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '{s1: '0, s2: '0, bm_d: 1'b0, tmr_d: 1'b0, l2_lat: 1'b0, flag: 1'b0,
                   wr_pend: 1'b0, wr_ofs: 8'h00, cfg: `CBIS_CFG_RST, dmask: `CBIS_DMASK_RST,
                   pmask: `CBIS_PMASK_RST, pcfg: `CBIS_PCFG_RST, rdata: 32'h00000000};
        end
        else
        begin
            r <= n;
        end
    end

    // ====================================================
    // checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    trap_follows_a: assert property (power_fail_trap == // [R02] [R17]
        (r.cfg[`CBIS_CFG_PF_EN] && $past(pwr_fail_req || mains_loss_indication, 2)))
        else $error("power-fail output does not follow enabled sources");
    flag_set_a: assert property (bm_hit |=> r.flag) // [R07]
        else $error("window base write did not raise flag");
    flag_hold_a: assert property (r.flag && !flag_rd |=> r.flag) // [R19]
        else $error("flag dropped without clearing read");
    flag_clear_a: assert property (flag_rd && !bm_hit |=> !r.flag) // [R08]
        else $error("flag survived clearing read");
    modem_or_a: assert property (!r.dmask[`CBIS_DM_L3] |-> // [R04] [R20]
        level3_req == ($past({carrier_det, ring_ind}, 2) != 8'h00))
        else $error("level three not the OR of modem inputs");
    timer_edge_a: assert property ($rose(tmr) |=> r.l2_lat ##1 level2_req || r.dmask[0]) // [R03]
        else $error("timer edge not latched");
    dmask_gate_a: assert property (r.dmask[2] |-> !level4_req) // [R09]
        else $error("masked level four still asserted");
    sod_route_a: assert property (bus_interrupt_lines_oe != 8'h00 |-> // [R15]
        r.cfg[`CBIS_CFG_SOD_EN] && $onehot(bus_interrupt_lines_oe))
        else $error("bus line driven without routing");
    ack_data_a: assert property (pic_ack && call_instr != 24'h0 |=> hrdata[7:0] == `CBIS_CALL_OPC) // [R13]
        else $error("acknowledge read lacks call opcode");
endmodule // cbis_top

// File: src/cbis_consts.svh
// constants of the board interrupt steering block: offsets, fields, resets
// assumes inclusion by cbis_pkg only; holds definitions, no logic
// Behaviour
// R01: twelve levels, four direct plus eight controller
// R02: jumpered power-fail drives unmaskable level one
// R03: jumper picks either timer onto edge level
// R04: eight modem signals merge onto level three
// R05: software can read all eight modem signals
// R06: level four: flag, or jumpered bus line
// R07: master write to window base sets flag
// R08: processor read of base clears flag
// R09: direct levels maskable except power-fail
// R10: eight channel ready requests feed controller only
// R11: request outranking in-service level raises output
// R12: one mask byte masks controller levels
// R13: acknowledge returns call, spacing four or eight
// R14: call targets within programmable 32/64 block
// R15: serial output bit jumpers onto bus line
// R16: shared window placed on any 4K boundary
// R17: mains-loss indication raises power-fail request
// R18: controller mode changeable anytime, no reset
// R19: flag held as level until cleared
// R20: level three is OR of modem signals
`ifndef CBIS_CONSTS_SVH
`define CBIS_CONSTS_SVH

// ====================================================
// register byte offsets
`define CBIS_OFS_CFG 8'h00
`define CBIS_OFS_DMASK 8'h04
`define CBIS_OFS_STAT 8'h08
`define CBIS_OFS_FLAG 8'h0c
`define CBIS_OFS_PMASK 8'h10
`define CBIS_OFS_PCFG 8'h14
`define CBIS_OFS_ACK 8'h18
`define CBIS_OFS_EOI 8'h1c

// ====================================================
// configuration (jumper), direct mask and controller config fields
`define CBIS_CFG_PF_EN 0
`define CBIS_CFG_TMR_EN 1
`define CBIS_CFG_TMR_SEL 2
`define CBIS_CFG_L4_BUS 3
`define CBIS_CFG_L4_LINE 6:4
`define CBIS_CFG_SOD_EN 7
`define CBIS_CFG_SOD_LINE 10:8
`define CBIS_CFG_PAGE 23:16
`define CBIS_DM_L2 0
`define CBIS_DM_L3 1
`define CBIS_DM_L4 2
`define CBIS_DM_SOD 3
`define CBIS_DM_CLR2 4
`define CBIS_PC_INT8 0
`define CBIS_PC_ROT 1
`define CBIS_PC_BASE 15:5

// ====================================================
// reset values and call opcode
`define CBIS_CFG_RST 32'h0000_0000
`define CBIS_DMASK_RST 32'h0000_0007
`define CBIS_PMASK_RST 8'hff
`define CBIS_PCFG_RST 16'h0000
`define CBIS_CALL_OPC 8'hcd

// ====================================================
// synchroniser bit positions
`define CBIS_SYNC_W 49
`define CBIS_S_PF 0
`define CBIS_S_ML 1
`define CBIS_S_T14 2
`define CBIS_S_T16 3
`define CBIS_S_MODEM 11:4
`define CBIS_S_RDY 19:12
`define CBIS_S_BUSN 27:20
`define CBIS_S_BMWR 28
`define CBIS_S_BMA 48:29

`endif

// File: src/cbis_pkg.sv
// types of the board interrupt steering block
// assumes cbis_consts.svh on the include path
package cbis_pkg;
`include "cbis_consts.svh"

    // state of the priority interrupt unit
    typedef struct packed {
        logic [7:0] isr;
        logic [2:0] lp;
    } cbis_pic_state_t;

    // state of the steering top
    typedef struct packed {
        logic [`CBIS_SYNC_W-1:0] s1;
        logic [`CBIS_SYNC_W-1:0] s2;
        logic bm_d;
        logic tmr_d;
        logic l2_lat;
        logic flag;
        logic wr_pend;
        logic [7:0] wr_ofs;
        logic [31:0] cfg;
        logic [31:0] dmask;
        logic [7:0] pmask;
        logic [15:0] pcfg;
        logic [31:0] rdata;
    } cbis_state_t;
endpackage

// File: src/cbis_pic.sv
// priority interrupt unit: eight levels, mask, in-service, call vectors
// assumes requests already synchronised to hclk
`timescale 1ns/10ps
module cbis_pic (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] req,
    input wire logic [7:0] mask,
    input wire logic rotate,
    input wire logic interval8,
    input wire logic [10:0] base,
    input wire logic ack,
    input wire logic eoi,
    output logic maskable_request_input,
    output logic [7:0] irr,
    output logic [7:0] isr,
    output logic [23:0] call_instr
);
    import cbis_pkg::*;

    cbis_pic_state_t st_r;
    cbis_pic_state_t st_nxt;
    logic [7:0] pend;
    logic [2:0] idx;
    logic [2:0] win_lvl;
    logic [2:0] win_rk;
    logic win_ok;
    logic [2:0] srv_lvl;
    logic [2:0] srv_rk;
    logic srv_ok;
    logic [15:0] tgt;

    // ====================================================
    // priority scan: rank 0 sits just after the lowest-priority pointer
    always_comb
    begin
        pend = req & ~mask; // [R10] [R12]
        win_ok = 1'b0;
        win_lvl = 3'h0;
        win_rk = 3'h0;
        srv_ok = 1'b0;
        srv_lvl = 3'h0;
        srv_rk = 3'h0;
        idx = 3'h0;
        for (int k = 7; k >= 0; k--)
        begin
            idx = st_r.lp + 3'(k) + 3'h1;
            if (pend[idx])
            begin
                win_ok = 1'b1;
                win_lvl = idx;
                win_rk = 3'(k);
            end
            if (st_r.isr[idx])
            begin
                srv_ok = 1'b1;
                srv_lvl = idx;
                srv_rk = 3'(k);
            end
        end
        // spacing picks the block size: 4 bytes in 32, 8 bytes in 64
        if (interval8) // [R13] [R14]
            tgt = {base[10:1], 6'h00} + {10'h000, win_lvl, 3'h0};
        else
            tgt = {base, 5'h00} + {11'h000, win_lvl, 2'h0};
        call_instr = win_ok ? {tgt[15:8], tgt[7:0], `CBIS_CALL_OPC} : 24'h000000;
        maskable_request_input = win_ok && (!srv_ok || win_rk < srv_rk); // [R11]
        irr = req;
        isr = st_r.isr;
    end

    // ====================================================
    // acknowledge sets in-service, end-of-interrupt clears the top one
    always_comb
    begin
        st_nxt = st_r;
        if (eoi && srv_ok)
        begin
            st_nxt.isr[srv_lvl] = 1'b0;
            st_nxt.lp = srv_lvl; // rotation: serviced level drops to last
        end
        if (ack && win_ok)
            st_nxt.isr[win_lvl] = 1'b1;
        if (!rotate)
            st_nxt.lp = 3'h7; // [R18] mode may flip at any time
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_r <= '{isr: 8'h00, lp: 3'h7};
        else
            st_r <= st_nxt;
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    maskable_request_input_cause_a: assert property (maskable_request_input |-> (req & ~mask) != 8'h00) // [R11]
        else $error("request output without unmasked request");
    ack_isr_a: assert property (ack && win_ok |=> st_r.isr[$past(win_lvl)]) // [R13]
        else $error("acknowledge did not mark level in service");
    masked_low_a: assert property (mask == 8'hff |-> !maskable_request_input) // [R12]
        else $error("request output while all levels masked");
endmodule // cbis_pic

// File: dv/cbis_bm_model.sv
// far-side model: an off-board bus master writing the shared window
// assumes hclk from the bench; the strobe idles low and idle address lines wander
`timescale 1ns/10ps
module cbis_bm_model (
    input wire logic hclk,
    output logic bm_wr_strobe,
    output logic [19:0] bm_addr
);
    logic busy;

    // ====================================================
    // idle bus
    initial
    begin
        busy = 1'h0;
        bm_wr_strobe = 1'h0;
        bm_addr = 20'h5a5a5;
    end

    // released address lines change every cycle, so a stale address never counts
    always @(posedge hclk)
    begin
        if (!busy)
            bm_addr <= ~bm_addr;
    end

    // one memory write; the address stands from a cycle before the strobe to after it
    task automatic write_mem(input logic [19:0] a);
        busy = 1'h1;
        bm_addr <= a;
        @(posedge hclk);
        bm_wr_strobe <= 1'h1;
        repeat (3) @(posedge hclk);
        bm_wr_strobe <= 1'h0;
        @(posedge hclk);
        busy = 1'h0;
    endtask
endmodule // cbis_bm_model

// File: dv/testbench.sv
// self-checking bench of the board interrupt steering block
// assumes cbis_pkg is compiled first and the far-side model sits in dv/
`timescale 1ns/10ps
module testbench;
    import cbis_pkg::*;
    logic hclk, hresetn, hwrite, hreadyout, hresp;
    logic pf, ml, t14, t16, l1, l2, l3, l4, mri, bm_wr_strobe;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    logic [3:0] ri, cd;
    logic [7:0] rdy, bl_i, bl_oe, page;
    logic [19:0] bm_addr;
    logic [10:0] base;
    int num_errors, checked, cyc, k;

    // ====================================================
    // clock and design
    initial
    begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end

    // bus lines are open-drain with pull-ups: the wire is low if anyone pulls it
    cbis_top u_cbis_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pwr_fail_req(pf), .mains_loss_indication(ml),
        .general_timer_14bit_out(t14), .general_timer_16bit_out(t16), .ring_ind(ri), .carrier_det(cd),
        .channel0_receive_ready(rdy[0]), .channel0_transmit_ready(rdy[1]),
        .channel1_receive_ready(rdy[2]), .channel1_transmit_ready(rdy[3]),
        .channel2_receive_ready(rdy[4]), .channel2_transmit_ready(rdy[5]),
        .channel3_receive_ready(rdy[6]), .channel3_transmit_ready(rdy[7]),
        .bus_interrupt_lines_n_i(bl_i & ~bl_oe), .bus_interrupt_lines_n_o(), .bus_interrupt_lines_oe(bl_oe),
        .bm_wr_strobe(bm_wr_strobe), .bm_addr(bm_addr), .power_fail_trap(l1), .level2_req(l2),
        .level3_req(l3), .level4_req(l4), .maskable_request_input(mri));
    cbis_bm_model u_cbis_bm_model (.hclk(hclk), .bm_wr_strobe(bm_wr_strobe), .bm_addr(bm_addr));

    // ====================================================
    // reporting, with a hang cut short well above the expected run
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask

    // ====================================================
    // bus transfers: one word, address phase then data phase, plus an idle edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        @(posedge hclk);
    endtask

    // pins pass two flops and latches one more, so four edges always suffice
    task automatic st;
        repeat (4) @(posedge hclk);
    endtask

    task automatic tp(input logic w);
        if (w)
            t16 <= 1'h1;
        else
            t14 <= 1'h1;
        repeat (3) @(posedge hclk);
        t14 <= 1'h0;
        t16 <= 1'h0;
    endtask

    // expected call target for a controller level
    function automatic logic [15:0] tgt(input logic [10:0] b, input int l, input logic e);
        tgt = e ? {b[10:1], 6'h0} + 16'(l * 8) : {b, 5'h0} + 16'(l * 4);
    endfunction

    // ====================================================
    // main sequence
    initial
    begin
        hresetn = 1'h0;
        {htrans, haddr, hwrite, hwdata, pf, ml, t14, t16, ri, cd, rdy} = '0;
        bl_i = 8'hff;
        hsize = 3'h2;
        num_errors = 0;
        checked = 0;
        cyc = 0;
        v = $urandom(32'h697a7254);
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(1'h0, 8'h00, 0); chk(rd, 32'h0, "cfg reset");
        xfer(1'h0, 8'h04, 0); chk(rd, 32'h7, "dmask reset");
        xfer(1'h0, 8'h10, 0); chk(rd, 32'hff, "pmask reset");
        // a write narrower than a word must leave the register alone
        hsize <= 3'h0;
        xfer(1'h1, 8'h10, 32'h0);
        hsize <= 3'h2;
        xfer(1'h0, 8'h10, 0); chk(rd, 32'hff, "byte write refused");
        xfer(1'h0, 8'h20, 0); chk(rd, 32'h0, "unmapped read");
        chk(hresp, 1'h0, "response");
        // power fail passes every mask, only its jumper gates it
        xfer(1'h1, 8'h00, 32'h1);
        pf <= 1'h1; st(); chk(l1, 1'h1, "pf trap");
        pf <= 1'h0; ml <= 1'h1; st(); chk(l1, 1'h1, "mains loss");
        ml <= 1'h0; st(); chk(l1, 1'h0, "pf idle");
        xfer(1'h1, 8'h00, 32'h0);
        pf <= 1'h1; st(); chk(l1, 1'h0, "pf unjumpered");
        pf <= 1'h0;
        // modem lines merge onto level three and stay readable one by one
        xfer(1'h1, 8'h04, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 32'h80 : $urandom;
            {cd, ri} <= v[7:0]; st(); chk(l3, |v[7:0], "level3");
            xfer(1'h0, 8'h08, 0); chk(rd[15:8], v[7:0], "modem status");
        end
        {cd, ri} <= 8'h01; xfer(1'h1, 8'h04, 32'h2); st(); chk(l3, 1'h0, "level3 masked");
        {cd, ri} <= 8'h00;
        // flag: only the window base sets it, it waits out a mask, a read clears it
        page = 8'($urandom);
        xfer(1'h1, 8'h00, {8'h0, page, 16'h0});
        xfer(1'h1, 8'h04, 32'h4);
        u_cbis_bm_model.write_mem({page, 12'h004}); st();
        xfer(1'h0, 8'h0c, 0); chk(rd, 32'h0, "non-base write");
        u_cbis_bm_model.write_mem({page, 12'h000}); st(); chk(l4, 1'h0, "level4 masked");
        xfer(1'h1, 8'h04, 32'h0); st(); chk(l4, 1'h1, "flag held");
        xfer(1'h0, 8'h0c, 0); chk(rd, 32'h1, "flag read");
        st(); chk(l4, 1'h0, "flag cleared");
        xfer(1'h0, 8'h0c, 0); chk(rd, 32'h0, "flag reread");
        // level four taken from a jumpered bus line instead
        k = $urandom % 8;
        xfer(1'h1, 8'h00, 32'h8 | (k << 4));
        bl_i <= ~(8'h1 << k); st(); chk(l4, 1'h1, "bus line level4");
        bl_i <= 8'hff; st(); chk(l4, 1'h0, "bus line idle");
        // each timer in turn, the other one must not reach level two
        for (int s = 0; s < 2; s++)
        begin
            xfer(1'h1, 8'h00, 32'h2 | (s << 2));
            tp(s == 0); st(); chk(l2, 1'h0, "unselected timer");
            tp(s == 1); st(); chk(l2, 1'h1, "selected timer");
            xfer(1'h1, 8'h04, 32'h10); st(); chk(l2, 1'h0, "timer cleared");
        end
        // serial output bit onto one chosen bus line
        k = $urandom % 8;
        xfer(1'h1, 8'h00, 32'h80 | (k << 8));
        xfer(1'h1, 8'h04, 32'h8); chk(bl_oe, 8'h1 << k, "serial out line");
        xfer(1'h1, 8'h04, 32'h0); chk(bl_oe, 8'h0, "serial out off");
        // controller: spacing changed between runs without a reset
        xfer(1'h1, 8'h10, 32'h0);
        for (int m = 0; m < 2; m++)
        begin
            base = 11'($urandom);
            xfer(1'h1, 8'h14, {16'h0, base, 4'h0, 1'(m)});
            k = 1 + $urandom % 7;
            rdy <= 8'h1 << k; st(); chk(mri, 1'h1, "ready request");
            xfer(1'h0, 8'h08, 0); chk(rd[23:16], 8'h1 << k, "ready status");
            xfer(1'h0, 8'h18, 0); chk(rd, {8'h0, tgt(base, k, m), 8'hcd}, "call target");
            st(); chk(mri, 1'h0, "same level in service");
            rdy <= rdy | 8'h1; st(); chk(mri, 1'h1, "higher level preempts");
            xfer(1'h0, 8'h18, 0); chk(rd, {8'h0, tgt(base, 0, m), 8'hcd}, "top call");
            xfer(1'h1, 8'h1c, 0);
            xfer(1'h1, 8'h1c, 0);
            xfer(1'h1, 8'h10, 32'hff); st(); chk(mri, 1'h0, "all masked");
            xfer(1'h1, 8'h10, ~(32'h1 << k)); st(); chk(mri, 1'h1, "one unmasked");
            xfer(1'h1, 8'h10, 32'h0);
            rdy <= 8'h0; st(); chk(mri, 1'h0, "no request");
            xfer(1'h0, 8'h18, 0); chk(rd, 32'h0, "empty acknowledge");
        end
        // rotating order switched on live: a serviced level drops to the bottom
        xfer(1'h1, 8'h14, {16'h0, base, 5'h02});
        rdy <= 8'h03; st();
        xfer(1'h0, 8'h18, 0); chk(rd, {8'h0, tgt(base, 0, 0), 8'hcd}, "rotate first");
        xfer(1'h1, 8'h1c, 0);
        xfer(1'h0, 8'h18, 0); chk(rd, {8'h0, tgt(base, 1, 0), 8'hcd}, "rotated order");
        xfer(1'h1, 8'h1c, 0);
        rdy <= 8'h00;
        xfer(1'h1, 8'h14, 32'h0);
        give_verdict();
    end
endmodule // testbench
